// *** gcsr_pkg.sv ***
// Purpose: Shared constants and types for the graphics palette and status register bank
// Assumes: 32-bit classic Wishbone, 16-bit registers in the low half of each word
// Notes:   All offsets are byte addresses of aligned words

package gcsr_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PALETTE_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_PALETTE_WRITE_DATA = 8'h04;
	localparam logic [7:0] OFS_PALETTE_READ_DATA  = 8'h08;
	localparam logic [7:0] OFS_BLANKING_IRQ_ADV   = 8'h0C;
	localparam logic [7:0] OFS_TEXT_CURSOR_X      = 8'h10;
	localparam logic [7:0] OFS_TEXT_CURSOR_Y      = 8'h14;
	localparam logic [7:0] OFS_DECOMP_STATUS      = 8'h18;
	localparam logic [7:0] OFS_DISPLAY_PIN_EN     = 8'h1C;
	localparam logic [7:0] OFS_DISPLAY_PIN_GLOBAL = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_PALETTE_ENABLE    = 15;
	localparam int BIT_PALETTE_BUSY      = 14;
	localparam int BIT_READ_TRIGGER      = 9;
	localparam int BIT_SW_ACCESS_ENABLE  = 8;
	localparam int BIT_BAD_CODE          = 5;
	localparam int BIT_BAD_BLOCK         = 4;
	localparam int BIT_LENGTH_MISMATCH   = 3;
	localparam int BIT_WRAPAROUND        = 2;
	localparam int BIT_DECOMPRESS_DONE   = 1;
	localparam int BIT_LAST_BLOCK_SEEN   = 0;
	localparam int BIT_PINS_OUTPUT_EN    = 0;

	// ----------------------------------------------------------------
	// Widths, depths and reset values
	// ----------------------------------------------------------------
	localparam int          PALETTE_DEPTH = 256;
	localparam int          CURSOR_W      = 11;
	localparam logic [15:0] REG_RESET     = 16'h0000;
	localparam logic [31:0] BUS_ZERO      = 32'h0000_0000;
	localparam logic [8:0]  ONE_9         = 9'h001;
	localparam logic [7:0]  ONE_8         = 8'h01;
	localparam logic [15:0] ONE_16        = 16'h0001;

	// Pending palette access
	typedef enum logic [1:0] {
		GCSR_IDLE,
		GCSR_WRITE,
		GCSR_READ
	} gcsr_op_t;

	// Decompressor finish report
	typedef struct packed {
		logic bad_code_error;
		logic bad_block_error;
		logic length_mismatch_error;
		logic wraparound_error;
		logic success;
		logic last_block_seen;
	} gcsr_decomp_result_t;

	// Whole state of the register bank
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        palette_enable;
		logic        sw_access_enable;
		logic        read_trigger;
		logic [7:0]  palette_entry_address;
		logic [15:0] palette_write_value;
		logic [15:0] palette_read_value;
		gcsr_op_t    op;
		logic [7:0]  vblank_irq_lead;
		logic [7:0]  hblank_irq_lead;
		logic [10:0] cursor_x_position;
		logic [10:0] cursor_y_position;
		logic [5:0]  decomp_status;
		logic [15:0] data_pin_enable;
		logic        pins_output_enable;
		logic [15:0] pin_data;
		logic [15:0] pin_oe;
		logic [15:0] pixel;
		logic        hblank_irq;
		logic        vblank_irq;
		logic [7:0]  first_pixel_count;
		logic        first_pixel_run;
		logic        first_pixel;
		logic        power_on;
		logic [15:0] power_count;
	} gcsr_state_t;

endpackage

// *** gcsr_top.sv ***
// Purpose: Palette, blanking lead, cursor, decompressor status and pin enable registers
// Assumes: All side inputs come from logic on clk_i; no synchronisers are needed
// Notes:   Wishbone answers every access one cycle after it is presented
//          Palette busy stands for one cycle per table access
//          Lead pulses and first-pixel strobe are registered outputs
//          Pixel path bypasses the table while software owns it
//
// What this block does
// R01: Palette translates pixels only while enabled
// R02: Busy flag high during software palette access
// R03: Software access enable blocks display palette reads
// R04: Software sets access enable around table access
// R05: Read starts on trigger rising with access enabled
// R06: Software clears read trigger after collecting data
// R07: Word or upper-byte write stores palette entry
// R08: Lower-byte write only updates low bits
// R09: Power sequencing timed by last write value
// R10: Eight-bit entry address selects read and write
// R11: Read data holds latest triggered read result
// R12: Vertical blanking interrupt fires lead cycles early
// R13: Horizontal blanking interrupt fires lead cycles early
// R14: Cursor X and Y read-only, eleven bits
// R15: Decompressor error flags read-only at fixed bits
// R16: Success sets done and last-block flags
// R17: Decompress command clears all status flags
// R18: Data pin driven only when both enables set
// R19: First pixel follows blanking start by setting
// R20: Busy set on trigger, cleared on completion

`timescale 1ns/1ps

module gcsr_top (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// Pixel path
	input  wire logic [15:0]                  pixel_i,
	output logic      [15:0]                  pixel_o,
	// Blanking timing
	input  wire logic [15:0]                  cycles_to_hblank_i,
	input  wire logic [15:0]                  cycles_to_vblank_i,
	input  wire logic                         hblank_start_i,
	input  wire logic [7:0]                   hblank_to_first_pixel_i,
	output logic                              hblank_irq_o,
	output logic                              vblank_irq_o,
	output logic                              first_pixel_o,
	// Text cursor
	input  wire logic                         cursor_update_i,
	input  wire logic [10:0]                  cursor_x_i,
	input  wire logic [10:0]                  cursor_y_i,
	// Decompressor
	input  wire logic                         decompress_command_i,
	input  wire logic                         decompress_finish_i,
	input  wire gcsr_pkg::gcsr_decomp_result_t decompress_result_i,
	// Display pins and power
	input  wire logic [15:0]                  display_data_i,
	output logic      [15:0]                  display_data_pin_o,
	output logic      [15:0]                  display_data_pin_oe_o,
	input  wire logic                         power_request_i,
	output logic                              display_power_control_o
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	gcsr_pkg::gcsr_state_t s;
	gcsr_pkg::gcsr_state_t next_s;
	logic [15:0]           palette_mem [gcsr_pkg::PALETTE_DEPTH];

	// Decode helpers
	logic        bus_req;
	logic        bus_wr;
	logic [15:0] lut_entry;
	logic [15:0] lut_pixel;

	// Byte-lane merge of a 16-bit register
	// Lanes left unselected keep their old value
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] sel);
		merge16 = old_v;
		if (sel[0]) begin
			merge16[7:0] = new_v[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = new_v[15:8];
		end
	endfunction

	// Blanking lead match, one cycle early to cover the output flop
	// Widened compare, so a lead of 255 cannot wrap to zero
	function automatic logic lead_hit(input logic [15:0] remain, input logic [7:0] lead);
		lead_hit = (remain == ({8'h00, lead} + gcsr_pkg::ONE_16));
	endfunction

	// ----------------------------------------------------------------
	// Bus decode and palette reads
	// ----------------------------------------------------------------
	// A request stands while cyc and stb are both high
	assign bus_req   = wb_cyc_i & wb_stb_i;
	// Writes land at the acked edge, while the master still holds them
	assign bus_wr    = bus_req & wb_we_i & s.ack;
	// Software read port and display read port of the table
	assign lut_entry = palette_mem[s.palette_entry_address];
	assign lut_pixel = palette_mem[pixel_i[7:0]];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0] ctl_new;
		logic [15:0] wd_new;
		logic [15:0] rd_word;
		ctl_new = gcsr_pkg::REG_RESET;
		wd_new  = gcsr_pkg::REG_RESET;
		rd_word = gcsr_pkg::REG_RESET;
		next_s  = s;

		// Classic single-cycle answer, ack drops the cycle after
		// Ack falls even if the master keeps stb high
		next_s.ack = bus_req & ~s.ack;

		// Read mux, loaded with the ack
		// Unmapped offsets read as zero
		case (wb_adr_i)
			gcsr_pkg::OFS_PALETTE_CONTROL: begin
				rd_word[gcsr_pkg::BIT_PALETTE_ENABLE]   = s.palette_enable;
				rd_word[gcsr_pkg::BIT_PALETTE_BUSY]     = (s.op != gcsr_pkg::GCSR_IDLE); // R02
				rd_word[gcsr_pkg::BIT_READ_TRIGGER]     = s.read_trigger;
				rd_word[gcsr_pkg::BIT_SW_ACCESS_ENABLE] = s.sw_access_enable;
				rd_word[7:0]                            = s.palette_entry_address;
			end
			gcsr_pkg::OFS_PALETTE_WRITE_DATA: begin
				rd_word = s.palette_write_value;
			end
			gcsr_pkg::OFS_PALETTE_READ_DATA: begin
				rd_word = s.palette_read_value;
			end
			gcsr_pkg::OFS_BLANKING_IRQ_ADV: begin
				rd_word = {s.vblank_irq_lead, s.hblank_irq_lead};
			end
			gcsr_pkg::OFS_TEXT_CURSOR_X: begin
				rd_word[10:0] = s.cursor_x_position; // R14
			end
			gcsr_pkg::OFS_TEXT_CURSOR_Y: begin
				rd_word[10:0] = s.cursor_y_position; // R14
			end
			gcsr_pkg::OFS_DECOMP_STATUS: begin
				rd_word[5:0] = s.decomp_status; // R15
			end
			gcsr_pkg::OFS_DISPLAY_PIN_EN: begin
				rd_word = s.data_pin_enable;
			end
			gcsr_pkg::OFS_DISPLAY_PIN_GLOBAL: begin
				rd_word[gcsr_pkg::BIT_PINS_OUTPUT_EN] = s.pins_output_enable;
			end
			default: begin
				rd_word = gcsr_pkg::REG_RESET;
			end
		endcase
		next_s.rdata = (bus_req & ~s.ack & ~wb_we_i) ? {16'h0000, rd_word} : gcsr_pkg::BUS_ZERO;

		// Pending palette access completes in one cycle
		case (s.op)
			gcsr_pkg::GCSR_WRITE: begin
				next_s.op = gcsr_pkg::GCSR_IDLE; // R20
			end
			gcsr_pkg::GCSR_READ: begin
				next_s.palette_read_value = lut_entry; // R11
				next_s.op                 = gcsr_pkg::GCSR_IDLE; // R20
			end
			default: begin
				next_s.op = gcsr_pkg::GCSR_IDLE;
			end
		endcase

		// Register writes take effect at the acked edge
		if (bus_wr) begin
			case (wb_adr_i)
				gcsr_pkg::OFS_PALETTE_CONTROL: begin
					ctl_new = merge16({s.palette_enable, 5'h00, s.read_trigger,
						s.sw_access_enable, s.palette_entry_address},
						wb_dat_i[15:0], wb_sel_i[1:0]);
					next_s.palette_enable        = ctl_new[gcsr_pkg::BIT_PALETTE_ENABLE];
					next_s.sw_access_enable      = ctl_new[gcsr_pkg::BIT_SW_ACCESS_ENABLE];
					next_s.read_trigger          = ctl_new[gcsr_pkg::BIT_READ_TRIGGER];
					next_s.palette_entry_address = ctl_new[7:0]; // R10
					// Only a 0 to 1 change of the trigger starts a read
					// Judged against the stored bit; a held 1 never retriggers
					if (ctl_new[gcsr_pkg::BIT_READ_TRIGGER] & ~s.read_trigger &
						ctl_new[gcsr_pkg::BIT_SW_ACCESS_ENABLE]) begin
						next_s.op = gcsr_pkg::GCSR_READ; // R05 R20
					end
				end
				gcsr_pkg::OFS_PALETTE_WRITE_DATA: begin
					wd_new                     = merge16(s.palette_write_value,
						wb_dat_i[15:0], wb_sel_i[1:0]);
					next_s.palette_write_value = wd_new; // R08 R09
					if (wb_sel_i[1]) begin
						next_s.op = gcsr_pkg::GCSR_WRITE; // R07 R20
					end
				end
				gcsr_pkg::OFS_BLANKING_IRQ_ADV: begin
					wd_new                 = merge16({s.vblank_irq_lead, s.hblank_irq_lead},
						wb_dat_i[15:0], wb_sel_i[1:0]);
					next_s.vblank_irq_lead = wd_new[15:8];
					next_s.hblank_irq_lead = wd_new[7:0];
				end
				gcsr_pkg::OFS_DISPLAY_PIN_EN: begin
					next_s.data_pin_enable = merge16(s.data_pin_enable,
						wb_dat_i[15:0], wb_sel_i[1:0]);
				end
				gcsr_pkg::OFS_DISPLAY_PIN_GLOBAL: begin
					if (wb_sel_i[0]) begin
						next_s.pins_output_enable = wb_dat_i[gcsr_pkg::BIT_PINS_OUTPUT_EN];
					end
				end
				default: begin
					next_s.op = next_s.op;
				end
			endcase
		end

		// Pixel translation, bypassed while disabled or owned by software
		// One flop either way, so latency does not change with the mode
		if (s.palette_enable & ~s.sw_access_enable) begin // R01 R03
			next_s.pixel = lut_pixel;
		end else begin
			next_s.pixel = pixel_i;
		end

		// Blanking interrupts ahead of the actual blanking start
		next_s.hblank_irq = lead_hit(cycles_to_hblank_i, s.hblank_irq_lead); // R13
		next_s.vblank_irq = lead_hit(cycles_to_vblank_i, s.vblank_irq_lead); // R12

		// First displayed pixel after the programmed delay
		next_s.first_pixel = 1'b0;
		// The output flop adds a cycle, so settings of zero and one fire at once
		if (hblank_start_i) begin
			if (hblank_to_first_pixel_i <= gcsr_pkg::ONE_8) begin
				next_s.first_pixel     = 1'b1; // R19
				next_s.first_pixel_run = 1'b0;
			end else begin
				next_s.first_pixel_run   = 1'b1;
				next_s.first_pixel_count = hblank_to_first_pixel_i - gcsr_pkg::ONE_8
					- gcsr_pkg::ONE_8;
			end
		end else if (s.first_pixel_run) begin
			if (s.first_pixel_count == 8'h00) begin
				next_s.first_pixel_run = 1'b0;
				next_s.first_pixel     = 1'b1; // R19
			end else begin
				next_s.first_pixel_count = s.first_pixel_count - gcsr_pkg::ONE_8;
			end
		end

		// Cursor position from the text engine
		// Both coordinates taken together on the update strobe
		if (cursor_update_i) begin
			next_s.cursor_x_position = cursor_x_i; // R14
			next_s.cursor_y_position = cursor_y_i; // R14
		end

		// Status clears on command; a finish in the same cycle wins
		// Last-block flag is also set by a successful finish
		if (decompress_command_i) begin
			next_s.decomp_status = 6'h00; // R17
		end
		if (decompress_finish_i) begin
			next_s.decomp_status[gcsr_pkg::BIT_BAD_CODE]        =
				decompress_result_i.bad_code_error; // R15
			next_s.decomp_status[gcsr_pkg::BIT_BAD_BLOCK]       =
				decompress_result_i.bad_block_error;
			next_s.decomp_status[gcsr_pkg::BIT_LENGTH_MISMATCH] =
				decompress_result_i.length_mismatch_error;
			next_s.decomp_status[gcsr_pkg::BIT_WRAPAROUND]      =
				decompress_result_i.wraparound_error;
			next_s.decomp_status[gcsr_pkg::BIT_DECOMPRESS_DONE] =
				decompress_result_i.success; // R16
			next_s.decomp_status[gcsr_pkg::BIT_LAST_BLOCK_SEEN] =
				decompress_result_i.success | decompress_result_i.last_block_seen; // R16
		end

		// Data pins gated by global and per-pin enables
		// Data masked too, so a disabled pin never shows pixel bits
		next_s.pin_oe   = s.pins_output_enable ? s.data_pin_enable : 16'h0000; // R18
		next_s.pin_data = display_data_i & next_s.pin_oe; // R18

		// Power output follows request after last write value plus one cycles
		// A request that flips back before the count ends restarts it
		if (power_request_i == s.power_on) begin
			next_s.power_count = 16'h0000;
		end else if (s.power_count >= s.palette_write_value) begin
			next_s.power_on    = power_request_i; // R09
			next_s.power_count = 16'h0000;
		end else begin
			next_s.power_count = s.power_count + gcsr_pkg::ONE_16; // R09
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset clears every field, state machine to idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s    <= '0;
			s.op <= gcsr_pkg::GCSR_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Palette memory write, one cycle after the data register write
	// No reset: entries are undefined until software fills them
	// Single write port, owned by the software side
	always_ff @(posedge clk_i) begin
		if (s.op == gcsr_pkg::GCSR_WRITE) begin
			palette_mem[s.palette_entry_address] <= s.palette_write_value; // R07
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output comes straight from the state flop
	assign wb_dat_o                = s.rdata;
	assign wb_ack_o                = s.ack;
	assign pixel_o                 = s.pixel;
	assign hblank_irq_o            = s.hblank_irq;
	assign vblank_irq_o            = s.vblank_irq;
	assign first_pixel_o           = s.first_pixel;
	assign display_data_pin_o      = s.pin_data;
	assign display_data_pin_oe_o   = s.pin_oe;
	assign display_power_control_o = s.power_on;

endmodule

// *** gcsr_top_sva.sv ***
// Purpose: Bus, blanking lead and pin checks for the palette and status register bank
// Assumes: Bound to gcsr_top; lead values mirrored from acknowledged bus writes
// Notes:   Sees only the top module's ports
`timescale 1ns/1ps
module gcsr_top_sva (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Timing and pins
	input wire logic [15:0] cycles_to_hblank_i,
	input wire logic [15:0] cycles_to_vblank_i,
	input wire logic        hblank_start_i,
	input wire logic [7:0]  hblank_to_first_pixel_i,
	input wire logic        hblank_irq_o,
	input wire logic        vblank_irq_o,
	input wire logic        first_pixel_o,
	input wire logic [15:0] display_data_pin_o,
	input wire logic [15:0] display_data_pin_oe_o
);
	logic [7:0] h_lead;
	logic [7:0] v_lead;
	logic       h_hit;
	logic       v_hit;
	logic       rd_ack;

	// Mirror of the lead register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_lead <= 8'h00;
			v_lead <= 8'h00;
		end else if (wb_ack_o && wb_we_i && wb_adr_i == gcsr_pkg::OFS_BLANKING_IRQ_ADV) begin
			if (wb_sel_i[0])
				h_lead <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				v_lead <= wb_dat_i[15:8];
		end
	end

	// Remaining count one above the lead
	assign h_hit = cycles_to_hblank_i == {8'h00, h_lead} + 16'h0001;
	assign v_hit = cycles_to_vblank_i == {8'h00, v_lead} + 16'h0001;
	assign rd_ack = wb_ack_o && !wb_we_i;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Bus request and its single answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_ack_answer: assert property (s_req |=> s_pulse)
		else $error("bus answer missing or too long");
	a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside answer");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper half of read data not zero");
	a_cursor_high_zero: assert property (
		rd_ack && wb_adr_i inside {8'h10, 8'h14} |-> wb_dat_o[15:11] == 5'h00)
		else $error("cursor upper bits not zero");
	a_status_high_zero: assert property (
		rd_ack && wb_adr_i == 8'h18 |-> wb_dat_o[15:6] == 10'h000)
		else $error("status upper bits not zero");
	a_pin_masked: assert property ((display_data_pin_o & ~display_data_pin_oe_o) == 16'h0000)
		else $error("data driven on disabled pin");
	a_hblank_lead: assert property (hblank_irq_o == $past(h_hit))
		else $error("horizontal lead pulse misplaced");
	a_vblank_lead: assert property (vblank_irq_o == $past(v_hit))
		else $error("vertical lead pulse misplaced");
	a_first_pixel: assert property (
		hblank_start_i && hblank_to_first_pixel_i == 8'h03 |-> ##3 first_pixel_o)
		else $error("first pixel pulse misplaced");
endmodule

// *** gcsr_top_test.sv ***
// Purpose: Random and corner tests of the palette and status register bank
// Assumes: Every bus access is answered within 50 cycles
// Notes:   Fixed seed, so runs repeat exactly
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module gcsr_top_test;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hblank_start_i;
	logic        cursor_update_i, decompress_command_i, decompress_finish_i;
	logic        power_request_i, hblank_irq_o, vblank_irq_o, first_pixel_o;
	logic        display_power_control_o;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i, hblank_to_first_pixel_i, hl, vl, adr [4];
	logic [10:0] cursor_x_i, cursor_y_i;
	logic [15:0] pixel_i, pixel_o, cycles_to_hblank_i, cycles_to_vblank_i, display_data_i;
	logic [15:0] display_data_pin_o, display_data_pin_oe_o, q, en, pal [256];
	logic [31:0] wb_dat_i, wb_dat_o;
	gcsr_pkg::gcsr_decomp_result_t decompress_result_i;
	int          errors, comparisons, i, h0, v0;
	int          hcnt = 0;
	int          vcnt = 0;

	gcsr_top u_dut (.*);

	// Bench clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Lead pulse counters
	always @(posedge clk_i) begin
		hcnt <= hcnt + int'(hblank_irq_o === 1'b1);
		vcnt <= vcnt + int'(vblank_irq_o === 1'b1);
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		end_of_test();
	end

	// Counts and verdict
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One classic bus cycle; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s = 4'h3);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			errors++;
		q = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Main sequence
	initial begin
		i = $urandom(57769);
		{wb_cyc_i, wb_stb_i, wb_we_i, hblank_start_i, cursor_update_i} = '0;
		{decompress_command_i, decompress_finish_i, power_request_i} = '0;
		{wb_sel_i, wb_adr_i, wb_dat_i, pixel_i, display_data_i} = '0;
		{cursor_x_i, cursor_y_i, decompress_result_i, hblank_to_first_pixel_i} = '0;
		{cycles_to_hblank_i, cycles_to_vblank_i} = {16'hffff, 16'hffff};
		{errors, comparisons} = '0;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 10; i++) begin
			bus(1'b0, 8'(i * 4), 16'h0000);
			`CHK(q, 16'h0000)
		end
		$display("test reset values done");
		for (i = 0; i < 4; i++) begin
			adr[i] = 8'($urandom);
			pal[adr[i]] = 16'($urandom);
			bus(1'b1, 8'h00, {8'h01, adr[i]});
			bus(1'b1, 8'h04, pal[adr[i]]);
		end
		bus(1'b1, 8'h04, 16'h00a5, 4'h1);
		bus(1'b0, 8'h04, 16'h0000);
		`CHK(q, {pal[adr[3]][15:8], 8'ha5})
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 8'h00, {8'h01, adr[i]});
			bus(1'b1, 8'h00, {8'h03, adr[i]});
			bus(1'b0, 8'h08, 16'h0000);
			`CHK(q, pal[adr[i]])
			bus(1'b0, 8'h00, 16'h0000);
			`CHK(q, {8'h03, adr[i]})
		end
		bus(1'b1, 8'h00, {8'h03, adr[0]});
		bus(1'b0, 8'h08, 16'h0000);
		`CHK(q, pal[adr[3]])
		$display("test palette access done");
		for (i = 0; i < 3; i++) begin
			bus(1'b1, 8'h00, i == 0 ? 16'h8000 : (i == 1 ? 16'h8100 : 16'h0000));
			pixel_i <= {8'($urandom), adr[1]};
			repeat (2) @(posedge clk_i);
			`CHK(pixel_o, i == 0 ? pal[adr[1]] : pixel_i)
		end
		$display("test pixel path done");
		hl = 8'($urandom_range(9, 1));
		vl = 8'($urandom_range(9, 1));
		bus(1'b1, 8'h0c, {vl, hl});
		bus(1'b0, 8'h0c, 16'h0000);
		`CHK(q, {vl, hl})
		{h0, v0} = {hcnt, vcnt};
		for (i = 12; i >= 0; i--) begin
			cycles_to_hblank_i <= 16'(i);
			cycles_to_vblank_i <= 16'(i + 1);
			@(posedge clk_i);
		end
		{cycles_to_hblank_i, cycles_to_vblank_i} <= {16'hffff, 16'hffff};
		repeat (2) @(posedge clk_i);
		`CHK(hcnt - h0, 1)
		`CHK(vcnt - v0, 1)
		hblank_to_first_pixel_i <= 8'h03;
		hblank_start_i <= 1'b1;
		@(posedge clk_i);
		hblank_start_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK(first_pixel_o, 1'b0)
		@(posedge clk_i);
		`CHK(first_pixel_o, 1'b1)
		$display("test blanking done");
		cursor_x_i <= 11'($urandom);
		cursor_y_i <= 11'($urandom);
		cursor_update_i <= 1'b1;
		@(posedge clk_i);
		cursor_update_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b1, 8'h10, 16'hffff);
		bus(1'b0, 8'h10, 16'h0000);
		`CHK(q, {5'h00, cursor_x_i})
		bus(1'b0, 8'h14, 16'h0000);
		`CHK(q, {5'h00, cursor_y_i})
		for (i = 0; i < 2; i++) begin
			decompress_result_i <= i == 0 ? 6'h02 : 6'($urandom);
			decompress_finish_i <= 1'b1;
			decompress_command_i <= 1'(i);
			@(posedge clk_i);
			decompress_finish_i <= 1'b0;
			decompress_command_i <= 1'b0;
			@(posedge clk_i);
			bus(1'b0, 8'h18, 16'h0000);
			`CHK(q, {10'h000, decompress_result_i[5:1], |decompress_result_i[1:0]})
			decompress_command_i <= 1'b1;
			@(posedge clk_i);
			decompress_command_i <= 1'b0;
			@(posedge clk_i);
			bus(1'b0, 8'h18, 16'h0000);
			`CHK(q, 16'h0000)
		end
		$display("test cursor and status done");
		for (i = 0; i < 2; i++) begin
			en = 16'($urandom);
			bus(1'b1, 8'h1c, en);
			bus(1'b1, 8'h20, 16'(i));
			display_data_i <= 16'($urandom);
			repeat (3) @(posedge clk_i);
			`CHK(display_data_pin_oe_o, i ? en : 16'h0000)
			`CHK(display_data_pin_o, display_data_i & (i ? en : 16'h0000))
		end
		bus(1'b1, 8'h04, 16'h0008);
		power_request_i <= 1'b1;
		repeat (9) @(posedge clk_i);
		`CHK(display_power_control_o, 1'b0)
		@(posedge clk_i);
		`CHK(display_power_control_o, 1'b1)
		$display("test pins and power done");
		end_of_test();
	end
endmodule

bind gcsr_top gcsr_top_sva u_sva (.*);
